// ==== include/adc_ctl_pkg.sv ====
package adc_ctl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int RES_W = 12;
    localparam int CHAN_W = 5;
    localparam int NUM_CORES = 4;
    localparam int NUM_CMP = 2;

    // Register indices
    localparam logic [ADDR_W-1:0] REG_WARMUP = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CMP0_CTRL = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CMP0_LO = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CMP0_HI = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CMP1_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CMP1_LO = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CMP1_HI = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CORE_STAT = 4'h9;
    localparam logic [ADDR_W-1:0] CMP_STRIDE = 4'h3;

    // Warm-up register fields
    localparam int WU_SEL_LSB = 8;
    localparam int WU_SHARED_BIT = 7;
    localparam logic [3:0] WU_MIN_CODE = 4'h4;
    localparam int WU_CNT_W = 16;

    // Comparator control fields
    localparam int CC_CHAN_LSB = 8;
    localparam int CC_EN_BIT = 7;
    localparam int CC_IE_BIT = 6;
    localparam int CC_STAT_BIT = 5;
    localparam int CC_SEL_BETWEEN_LIMITS_BIT = 4;
    localparam int CC_SEL_AT_OR_ABOVE_HIGH_BIT = 3;
    localparam int CC_SEL_BELOW_HIGH_BIT = 2;
    localparam int CC_SEL_AT_OR_ABOVE_LOW_BIT = 1;
    localparam int CC_SEL_BELOW_LOW_BIT = 0;
    localparam logic [CHAN_W-1:0] CHAN_MAX = 5'h15;

    // Interrupt status bit layout: cores 0..3, shared core, comparators 0..1
    localparam int IRQ_W = 7;
    localparam int IRQ_SHARED_BIT = 4;
    localparam int IRQ_CMP_LSB = 5;

    typedef struct packed {
        logic enable;
        logic irq_en;
        logic sel_between_limits;
        logic sel_at_or_above_high;
        logic sel_below_high;
        logic sel_at_or_above_low;
        logic sel_below_low;
        logic [RES_W-1:0] compare_low_limit;
        logic [RES_W-1:0] compare_high_limit;
    } cmp_cfg_s;

    typedef struct packed {
        logic valid;
        logic [CHAN_W-1:0] channel;
        logic [RES_W-1:0] value;
    } conv_result_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;
endpackage : adc_ctl_pkg

// ==== hw/adc_warmup_timer.sv ====
`timescale 1ns/1ps
module adc_warmup_timer
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Power request and selected delay code
    input wire logic power_req,
    input wire logic [3:0] delay_sel,
    // Ready level and one-cycle ready event
    output logic ready,
    output logic ready_pulse
);
    typedef enum logic [1:0] {ST_OFF, ST_WARM, ST_READY} wu_state_e;
    typedef struct packed {
        wu_state_e st;
        logic [WU_CNT_W-1:0] cnt;
        logic pulse;
    } wu_state_s;

    wu_state_s q, next_q;

    // Codes below the minimum behave as the minimum
    function automatic logic [WU_CNT_W:0] delay_cycles(input logic [3:0] code);
        logic [3:0] c;
        c = (code < WU_MIN_CODE) ? WU_MIN_CODE : code;
        delay_cycles = (WU_CNT_W + 1)'(1) << c;
    endfunction : delay_cycles

    always_comb begin
        logic [WU_CNT_W:0] limit;
        limit = delay_cycles(delay_sel);
        next_q = q;
        next_q.pulse = 1'b0;
        if (!power_req) begin
            next_q.st = ST_OFF;
            next_q.cnt = '0;
        end else begin
            unique case (q.st)
                ST_OFF: begin
                    next_q.st = ST_WARM;
                    next_q.cnt = '0;
                end
                ST_WARM: begin
                    if ({1'b0, q.cnt} >= limit - 1'b1) begin // [RL1]
                        next_q.st = ST_READY;
                        next_q.pulse = 1'b1;
                    end else begin
                        next_q.cnt = q.cnt + 1'b1;
                    end
                end
                ST_READY: begin
                    next_q.st = ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{st: ST_OFF, cnt: '0, pulse: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign ready = (q.st == ST_READY);
    assign ready_pulse = q.pulse;

    a_warm_min_delay: assert property (@(posedge clk) disable iff (sys_rst) // [RL1]
        $rose(ready) |-> $past(power_req, 16))
        else $error("core ready before the shortest warm-up");
endmodule : adc_warmup_timer

// ==== hw/adc_digital_comparator.sv ====
`timescale 1ns/1ps
module adc_digital_comparator
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration and incoming results
    input wire adc_ctl_pkg::cmp_cfg_s cfg,
    input wire adc_ctl_pkg::conv_result_s result,
    // Channel field read by software
    input wire logic chan_read,
    // Status
    output logic [CHAN_W-1:0] event_channel_number,
    output logic event_stat,
    output logic event_pulse
);
    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic stat;
        logic pulse;
    } cmp_state_s;

    cmp_state_s q, next_q;
    logic hit;

    always_comb begin
        logic lo_ge;
        logic hi_ge;
        lo_ge = result.value >= cfg.compare_low_limit;
        hi_ge = result.value >= cfg.compare_high_limit;
        hit = (cfg.sel_between_limits && lo_ge && !hi_ge) // [RL9]
            || (cfg.sel_at_or_above_high && hi_ge) // [RL10]
            || (cfg.sel_below_high && !hi_ge) // [RL11]
            || (cfg.sel_at_or_above_low && lo_ge) // [RL12]
            || (cfg.sel_below_low && !lo_ge); // [RL13]
        next_q = q;
        next_q.pulse = 1'b0;
        if (chan_read) begin
            next_q.stat = 1'b0; // [RL8]
        end
        if (!cfg.enable) begin
            next_q.stat = 1'b0; // [RL6]
        end else if (result.valid && hit && result.channel <= CHAN_MAX) begin
            // Channel, status and event move together; a new event beats the read clear
            next_q.chan = result.channel; // [RL5] [RL14]
            next_q.stat = 1'b1; // [RL8]
            next_q.pulse = 1'b1; // [RL14]
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '{chan: '0, stat: 1'b0, pulse: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign event_channel_number = q.chan;
    assign event_stat = q.stat;
    assign event_pulse = q.pulse;

    a_disabled_stat: assert property (@(posedge clk) disable iff (sys_rst) // [RL6]
        !cfg.enable |=> !event_stat)
        else $error("status set while comparator disabled");
    a_event_together: assert property (@(posedge clk) disable iff (sys_rst) // [RL14]
        event_pulse |-> event_stat && event_channel_number == $past(result.channel))
        else $error("event without status or channel");
    a_read_clears: assert property (@(posedge clk) disable iff (sys_rst) // [RL8]
        chan_read && !(result.valid && hit && cfg.enable) |=> !event_stat)
        else $error("channel read did not clear status");
    a_below_low: assert property (@(posedge clk) disable iff (sys_rst) // [RL13]
        cfg.enable && result.valid && cfg.sel_below_low && result.channel <= CHAN_MAX
        && result.value < cfg.compare_low_limit |=> event_pulse)
        else $error("below-low event missed");
    a_at_high: assert property (@(posedge clk) disable iff (sys_rst) // [RL10]
        cfg.enable && result.valid && cfg.sel_at_or_above_high && result.channel <= CHAN_MAX
        && result.value >= cfg.compare_high_limit |=> event_pulse)
        else $error("at-or-above-high event missed");
endmodule : adc_digital_comparator

// ==== hw/adc_ctl_top.sv ====
`timescale 1ns/1ps
// Functional notes
// [RL1] Warm-up delay is 2^code source clocks; codes under 4 give 16.
// [RL2] Shared core ready raises the interrupt only when its enable is set.
// [RL3] Each dedicated core 0..3 ready raises the interrupt when its enable is set.
// [RL4] Two identical comparators, each with its own control register.
// [RL5] Event writes channel number into a read-only five-bit field; codes above 21 reserved.
// [RL6] Disabled comparator does nothing and its status bit reads zero.
// [RL7] Comparator interrupt enable lets each comparison event raise the interrupt.
// [RL8] Status bit set by an event, cleared when software reads the channel field.
// [RL9] Between select: event when low limit <= result < high limit.
// [RL10] High-high select: event when result >= high limit.
// [RL11] High-low select: event when result < high limit.
// [RL12] Low-high select: event when result >= low limit.
// [RL13] Low-low select: event when result < low limit.
// [RL14] Any enabled condition true gives event; channel, status, interrupt update together.
module adc_ctl_top
    import adc_ctl_pkg::*;
#(
    parameter int CORES = NUM_CORES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Converter cores: power requests in, ready levels out
    input wire logic [CORES-1:0] core_power_req,
    input wire logic shared_power_req,
    output logic [CORES-1:0] core_ready,
    output logic shared_ready,
    // Completed conversion results, one per comparator
    input wire adc_ctl_pkg::conv_result_s cmp_result0,
    input wire adc_ctl_pkg::conv_result_s cmp_result1,
    // Common converter interrupt
    output logic adc_irq
);
    typedef struct packed {
        logic [3:0] core_powerup_delay_sel;
        logic shared_core_ready_irq_en;
        logic [CORES-1:0] core_ready_irq_en;
        logic [NUM_CMP-1:0] comparator_enable;
        logic [NUM_CMP-1:0] comparator_irq_en;
        logic [NUM_CMP-1:0][4:0] sel;
        logic [NUM_CMP-1:0][RES_W-1:0] low_limit;
        logic [NUM_CMP-1:0][RES_W-1:0] high_limit;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [DATA_W-1:0] rdata;
    } top_state_s;

    top_state_s q, next_q;
    logic [CORES-1:0] core_pulse;
    logic shared_pulse;
    logic [NUM_CMP-1:0] cmp_pulse;
    logic [NUM_CMP-1:0] cmp_stat;
    logic [NUM_CMP-1:0][CHAN_W-1:0] cmp_chan;
    logic [NUM_CMP-1:0] chan_read;
    cmp_cfg_s [NUM_CMP-1:0] cfg;
    conv_result_s [NUM_CMP-1:0] results;
    logic [IRQ_W-1:0] irq_event;

    assign results[0] = cmp_result0;
    assign results[1] = cmp_result1;

    // One warm-up setting serves every core
    for (genvar i = 0; i < CORES; i++) begin : g_core
        adc_warmup_timer u_warm (
            .clk(clk),
            .sys_rst(sys_rst),
            .power_req(core_power_req[i]),
            .delay_sel(q.core_powerup_delay_sel), // [RL1]
            .ready(core_ready[i]),
            .ready_pulse(core_pulse[i])
        );
    end

    adc_warmup_timer u_warm_shared (
        .clk(clk),
        .sys_rst(sys_rst),
        .power_req(shared_power_req),
        .delay_sel(q.core_powerup_delay_sel), // [RL1]
        .ready(shared_ready),
        .ready_pulse(shared_pulse)
    );

    for (genvar c = 0; c < NUM_CMP; c++) begin : g_cmp // [RL4]
        assign cfg[c] = '{
            enable: q.comparator_enable[c],
            irq_en: q.comparator_irq_en[c],
            sel_between_limits: q.sel[c][CC_SEL_BETWEEN_LIMITS_BIT],
            sel_at_or_above_high: q.sel[c][CC_SEL_AT_OR_ABOVE_HIGH_BIT],
            sel_below_high: q.sel[c][CC_SEL_BELOW_HIGH_BIT],
            sel_at_or_above_low: q.sel[c][CC_SEL_AT_OR_ABOVE_LOW_BIT],
            sel_below_low: q.sel[c][CC_SEL_BELOW_LOW_BIT],
            compare_low_limit: q.low_limit[c],
            compare_high_limit: q.high_limit[c]
        };
        assign chan_read[c] = reg_rd && reg_addr == ctrl_addr(c);
        adc_digital_comparator u_cmp (
            .clk(clk),
            .sys_rst(sys_rst),
            .cfg(cfg[c]),
            .result(results[c]),
            .chan_read(chan_read[c]), // [RL8]
            .event_channel_number(cmp_chan[c]),
            .event_stat(cmp_stat[c]),
            .event_pulse(cmp_pulse[c])
        );
    end

    function automatic logic [ADDR_W-1:0] ctrl_addr(input int c);
        ctrl_addr = REG_CMP0_CTRL + ADDR_W'(c) * CMP_STRIDE;
    endfunction : ctrl_addr

    function automatic logic [DATA_W-1:0] pad(input logic [RES_W-1:0] v);
        pad = {{(DATA_W-RES_W){1'b0}}, v};
    endfunction : pad

    // Hardware events; each gated by its own enable
    always_comb begin
        irq_event = '0;
        irq_event[CORES-1:0] = core_pulse & q.core_ready_irq_en; // [RL3]
        irq_event[IRQ_SHARED_BIT] = shared_pulse & q.shared_core_ready_irq_en; // [RL2]
        irq_event[IRQ_CMP_LSB +: NUM_CMP] = cmp_pulse & q.comparator_irq_en; // [RL7] [RL14]
    end

    always_comb begin
        next_q = q;
        if (reg_wr) begin
            unique case (reg_addr)
                REG_WARMUP: begin
                    next_q.core_powerup_delay_sel = reg_wdata[WU_SEL_LSB +: 4];
                    next_q.shared_core_ready_irq_en = reg_wdata[WU_SHARED_BIT];
                    next_q.core_ready_irq_en = reg_wdata[CORES-1:0];
                end
                REG_IRQ_STAT: next_q.irq_stat = q.irq_stat & ~reg_wdata[IRQ_W-1:0];
                REG_IRQ_MASK: next_q.irq_mask = reg_wdata[IRQ_W-1:0];
                default: begin
                    for (int c = 0; c < NUM_CMP; c++) begin
                        if (reg_addr == ctrl_addr(c)) begin
                            next_q.comparator_enable[c] = reg_wdata[CC_EN_BIT];
                            next_q.comparator_irq_en[c] = reg_wdata[CC_IE_BIT];
                            next_q.sel[c] = reg_wdata[CC_SEL_BETWEEN_LIMITS_BIT:CC_SEL_BELOW_LOW_BIT];
                        end
                        if (reg_addr == ctrl_addr(c) + 4'h1) begin
                            next_q.low_limit[c] = reg_wdata[RES_W-1:0];
                        end
                        if (reg_addr == ctrl_addr(c) + 4'h2) begin
                            next_q.high_limit[c] = reg_wdata[RES_W-1:0];
                        end
                    end
                end
            endcase
        end
        // Set after the write-one clear so a same-cycle event survives
        next_q.irq_stat = next_q.irq_stat | irq_event;
        next_q.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_WARMUP: begin
                    next_q.rdata[WU_SEL_LSB +: 4] = q.core_powerup_delay_sel;
                    next_q.rdata[WU_SHARED_BIT] = q.shared_core_ready_irq_en;
                    next_q.rdata[CORES-1:0] = q.core_ready_irq_en;
                end
                REG_IRQ_STAT: next_q.rdata[IRQ_W-1:0] = q.irq_stat;
                REG_IRQ_MASK: next_q.rdata[IRQ_W-1:0] = q.irq_mask;
                REG_CORE_STAT: next_q.rdata[CORES:0] = {shared_ready, core_ready};
                default: begin
                    for (int c = 0; c < NUM_CMP; c++) begin
                        if (reg_addr == ctrl_addr(c)) begin
                            next_q.rdata[CC_CHAN_LSB +: CHAN_W] = cmp_chan[c]; // [RL5]
                            next_q.rdata[CC_EN_BIT] = q.comparator_enable[c];
                            next_q.rdata[CC_IE_BIT] = q.comparator_irq_en[c];
                            next_q.rdata[CC_STAT_BIT] = cmp_stat[c];
                            next_q.rdata[CC_SEL_BETWEEN_LIMITS_BIT:CC_SEL_BELOW_LOW_BIT] = q.sel[c];
                        end
                        if (reg_addr == ctrl_addr(c) + 4'h1) begin
                            next_q.rdata = pad(q.low_limit[c]);
                        end
                        if (reg_addr == ctrl_addr(c) + 4'h2) begin
                            next_q.rdata = pad(q.high_limit[c]);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign reg_rdata = q.rdata;
    // The event itself drives the line, so it rises with channel and status rather than a cycle later
    assign adc_irq = |((q.irq_stat | irq_event) & q.irq_mask); // [RL14]

    a_core_irq_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RL3]
        (q.irq_stat[CORES-1:0] & ~$past(q.irq_stat[CORES-1:0]) & ~$past(q.core_ready_irq_en)) == '0)
        else $error("core ready latched while its enable is clear");
    a_shared_irq: assert property (@(posedge clk) disable iff (sys_rst) // [RL2]
        shared_pulse && q.shared_core_ready_irq_en |=> q.irq_stat[IRQ_SHARED_BIT])
        else $error("shared core ready event lost");
    a_cmp_irq: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
        cmp_pulse[1] && q.comparator_irq_en[1] && q.irq_mask[IRQ_CMP_LSB + 1] |-> adc_irq)
        else $error("comparator 1 event did not raise interrupt");
    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        adc_irq && !reg_wr |=> adc_irq)
        else $error("interrupt dropped with no software write");
    a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside the cycle after a read");
endmodule : adc_ctl_top

// ==== bench/adc_ctl_top_bench.sv ====
`timescale 1ns/1ps
module adc_ctl_top_bench;
    import adc_ctl_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [NUM_CORES-1:0] core_power_req = '0;
    logic shared_power_req = 1'b0;
    logic [NUM_CORES-1:0] core_ready;
    logic shared_ready;
    conv_result_s cmp_result0 = '0;
    conv_result_s cmp_result1 = '0;
    logic adc_irq;
    wire logic [4:0] all_ready = {shared_ready, core_ready};
    int n_mismatch = 0;
    int samples_checked = 0;
    localparam logic [11:0] VALS [4] = '{12'h063, 12'h064, 12'h0c7, 12'h0c8};

    always #2.5 clk = ~clk;

    adc_ctl_top i_dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .core_power_req(core_power_req),
        .shared_power_req(shared_power_req),
        .core_ready(core_ready),
        .shared_ready(shared_ready),
        .cmp_result0(cmp_result0),
        .cmp_result1(cmp_result1),
        .adc_irq(adc_irq)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, what, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    function automatic logic [ADDR_W-1:0] cbase(input int k);
        return REG_CMP0_CTRL + ((k == 1) ? CMP_STRIDE : 4'h0);
    endfunction : cbase

    task automatic send(input int k, input logic [4:0] ch, input logic [11:0] v);
        conv_result_s r;
        r = {1'b1, ch, v};
        @(posedge clk);
        if (k == 0) cmp_result0 <= r;
        else cmp_result1 <= r;
        @(posedge clk);
        cmp_result0.valid <= 1'b0;
        cmp_result1.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send

    task automatic t_reset_values();
        logic [15:0] d;
        for (int i = 0; i < 10; i++) begin
            reg_read(i[3:0], d);
            check(d, 16'h0000, "reset value");
        end
        reg_write(4'hf, 16'hffff);
        reg_read(4'hf, d);
        check(d, 16'h0000, "unmapped read");
        $display("test reset values done");
    endtask : t_reset_values

    task automatic t_warm(input logic [3:0] code, input int idx, input logic en);
        logic [15:0] d;
        int n;
        int lim;
        lim = (code < 4) ? 16 : (1 << code);
        n = 0;
        reg_write(REG_IRQ_MASK, 16'h001f);
        reg_write(REG_IRQ_STAT, 16'h007f);
        reg_write(REG_WARMUP, {4'h0, code, en ? ((idx == 4) ? 8'h80 : (8'h01 << idx)) : 8'h00});
        @(posedge clk);
        if (idx == 4) shared_power_req <= 1'b1;
        else core_power_req[idx] <= 1'b1;
        while (all_ready[idx] !== 1'b1 && n < lim + 40) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'(n >= lim && n <= lim + 3), 16'h0001, "warm-up length");
        repeat (3) @(posedge clk);
        #1 check({15'h0, adc_irq}, {15'h0, en}, "ready interrupt");
        reg_read(REG_CORE_STAT, d);
        check(d, 16'h0001 << idx, "ready status");
        @(posedge clk);
        core_power_req <= '0;
        shared_power_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check({11'h0, all_ready}, 16'h0000, "ready drops");
        $display("test warm-up code %0d core %0d done", code, idx);
    endtask : t_warm

    task automatic t_compare(input int k);
        logic [15:0] d;
        logic [11:0] v;
        logic hit;
        reg_write(cbase(k) + 4'h1, 16'd100);
        reg_write(cbase(k) + 4'h2, 16'd200);
        for (int s = 0; s < 5; s++) begin
            reg_write(cbase(k), 16'h0080 | (16'h0001 << s));
            for (int i = 0; i < 4; i++) begin
                v = VALS[i];
                case (s)
                    0: hit = (v < 12'd100);
                    1: hit = (v >= 12'd100);
                    2: hit = (v < 12'd200);
                    3: hit = (v >= 12'd200);
                    default: hit = (v >= 12'd100) && (v < 12'd200);
                endcase
                send(k, 5'(i * 5 + s), v);
                reg_read(cbase(k), d);
                check({15'h0, d[CC_STAT_BIT]}, {15'h0, hit}, "event status");
                if (hit) check({11'h0, d[12:8]}, 16'(i * 5 + s), "channel field");
                reg_read(cbase(k), d);
                check({15'h0, d[CC_STAT_BIT]}, 16'h0000, "status after read");
            end
        end
        reg_write(REG_IRQ_MASK, 16'h0060);
        reg_write(REG_IRQ_STAT, 16'h007f);
        reg_write(cbase(k), 16'h00c2);
        send(k, 5'd21, 12'd150);
        check({15'h0, adc_irq}, 16'h0001, "compare interrupt");
        reg_read(cbase(k), d);
        check({11'h0, d[12:8]}, 16'd21, "top channel");
        reg_write(REG_IRQ_STAT, 16'h0020 << k);
        @(posedge clk);
        #1 check({15'h0, adc_irq}, 16'h0000, "interrupt cleared");
        // Interrupt enable off: an event still happens but must stay silent
        reg_write(cbase(k), 16'h0082);
        send(k, 5'd7, 12'd150);
        check({15'h0, adc_irq}, 16'h0000, "interrupt suppressed");
        reg_read(cbase(k), d);
        send(k, 5'd22, 12'd150);
        reg_read(cbase(k), d);
        check({15'h0, d[CC_STAT_BIT]}, 16'h0000, "reserved channel");
        send(k, 5'd3, 12'd150);
        reg_write(cbase(k), 16'h0002);
        @(posedge clk);
        reg_read(cbase(k), d);
        check({15'h0, d[CC_STAT_BIT]}, 16'h0000, "disable clears status");
        send(k, 5'd4, 12'd150);
        reg_read(cbase(k), d);
        check({15'h0, d[CC_STAT_BIT]}, 16'h0000, "disabled no event");
        $display("test comparator %0d done", k);
    endtask : t_compare

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // The longest warm-up is 8192 cycles; everything else adds a few hundred
    initial begin
        #(60000 * 5);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_warm(4'h0, 0, 1'b1);
        t_warm(4'h4, 3, 1'b0);
        t_warm(4'h5, 4, 1'b1);
        t_warm(4'h6, 4, 1'b0);
        t_warm(4'hd, 2, 1'b1);
        t_compare(0);
        t_compare(1);
        tally_and_finish();
    end
endmodule : adc_ctl_top_bench
